// File: hw/rsc_pkg.sv
// package: constants for the reset source combiner
package rsc_pkg;
   // ************************************************
   // reset-cause register field positions
   // ************************************************
   localparam int unsigned CAUSE_W      = 16;
   localparam int unsigned POS_POR      = 0;
   localparam int unsigned POS_BROWNOUT = 1;
   localparam int unsigned POS_WDT      = 4;
   localparam int unsigned POS_SWRST    = 6;
   localparam int unsigned POS_PIN      = 7;
   localparam int unsigned POS_CFGMIS   = 9;
   localparam int unsigned POS_ILLEGAL  = 14;
   localparam int unsigned POS_TRAP     = 15;
   // flags that exist; all other bits are other blocks' and read as zero
   localparam logic [15:0] CAUSE_MASK   = 16'hC2D3;
   // value left by a power-on reset: only the two lowest flags set
   localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;

   // ************************************************
   // oscillator control
   // ************************************************
   localparam int unsigned OSC_SEL_W   = 3;
   localparam int unsigned OSC_NEW_POS = 8;
   localparam int unsigned OSC_CUR_POS = 12;
   localparam logic [15:0] OSC_RST_VAL = 16'h0000;

   // ************************************************
   // reset stretch: cycles the master reset stays asserted after sources
   // ************************************************
   localparam int unsigned STRETCH_CYC = 4;
   localparam int unsigned NUM_ILLEGAL = 4;
endpackage

// File: hw/rsc_sync.sv
// module: two-flop synchronisers for all asynchronous reset sources
`timescale 1ns/100ps
module rsc_sync #(
   parameter int unsigned W = 11
) (
   input  wire logic    mclk_i,
   input  wire logic    rst_b_i,
   rsc_sync_if.src      sif
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } rsc_sync_t;

   rsc_sync_t st;
   rsc_sync_t next_st;

   // ************************************************
   // synchroniser chain
   // ************************************************
   always_comb begin
      next_st.meta   = sif.raw;
      next_st.stable = st.meta;
   end

   // power-on source must survive the sync path: stages only flush on the
   // clocked reset when the whole block is being held anyway
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sif.synced = st.stable;
endmodule // rsc_sync

// File: hw/rsc_sync_if.sv
// interface: synchronised source levels passed to the combiner core
`timescale 1ns/100ps
interface rsc_sync_if #(parameter int unsigned W = 11);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (input raw, output synced);
   modport dst (output raw, input synced);
endinterface

// File: hw/rsc_top.sv
// module: reset source combiner with cause flags and oscillator reload
//
// What this block does
// - Combine all eight reset sources into one reset
// - Any active source asserts master reset, unmasked
// - Reset forces defined registers, others keep contents
// - Four illegal causes share one cause flag
// - Each reset type sets its own flag
// - Power-on clears register, sets two lowest flags
// - Software may write any flag; hardware sets and power-on in the same cycle win
// - Software setting a flag never causes reset
// - Every reset reloads oscillator selection from config
// - Register value after reset depends on type
`timescale 1ns/100ps
module rsc_top #(
   parameter int unsigned STRETCH = rsc_pkg::STRETCH_CYC
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        power_on_i,
   input  wire logic        brownout_i,
   input  wire logic        master_clear_pin_reset_b_i,
   input  wire logic        reset_instr_i,
   input  wire logic        watchdog_timeout_i,
   input  wire logic        config_mismatch_i,
   input  wire logic        trap_conflict_i,
   input  wire logic [3:0]  illegal_cause_i,
   input  wire logic [2:0]  initial_osc_select_bits_i,
   input  wire logic        cause_wr_i,
   input  wire logic [15:0] cause_wdata_i,
   output logic             master_system_reset_o,
   output logic [15:0]      reset_cause_register_o,
   output logic [15:0]      oscillator_control_register_o
);
   localparam int unsigned NSRC = 7 + rsc_pkg::NUM_ILLEGAL;
   localparam int unsigned CW   = $clog2(STRETCH + 1);

   // a zero stretch would let reset drop before the sources are seen low
   if (STRETCH < 1 || STRETCH > 255) begin : g_bad_stretch
      $error("rsc_top: STRETCH must be 1..255");
   end

   typedef struct packed {
      logic            rst;
      logic [CW-1:0]   cnt;
      logic [15:0]     cause;
      logic [15:0]     osc;
      logic [2:0]      cfg;
   } rsc_state_t;

   rsc_state_t st;
   rsc_state_t next_st;

   // ************************************************
   // source synchronisation
   // ************************************************
   rsc_sync_if #(.W(NSRC)) sif ();

   assign sif.raw = {illegal_cause_i, trap_conflict_i, config_mismatch_i,
                     watchdog_timeout_i, reset_instr_i,
                     ~master_clear_pin_reset_b_i, brownout_i, power_on_i};

   rsc_sync #(.W(NSRC)) u_sync (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .sif     (sif)
   );

   logic       src_por;
   logic       src_bor;
   logic       src_pin;
   logic       src_sw;
   logic       src_wdt;
   logic       src_cm;
   logic       src_trap;
   logic [3:0] src_ill;
   logic       src_illegal;
   logic       any_src;

   assign src_por     = sif.synced[0];
   assign src_bor     = sif.synced[1];
   assign src_pin     = sif.synced[2];
   assign src_sw      = sif.synced[3];
   assign src_wdt     = sif.synced[4];
   assign src_cm      = sif.synced[5];
   assign src_trap    = sif.synced[6];
   assign src_ill     = sif.synced[10:7];
   assign src_illegal = |src_ill;
   // plain OR: no source can hide another
   assign any_src = src_por | src_bor | src_pin | src_sw | src_wdt
                  | src_cm | src_trap | src_illegal;

   // ************************************************
   // next-state logic
   // ************************************************
   logic [15:0] hw_set;

   always_comb begin
      hw_set = 16'h0000;
      hw_set[rsc_pkg::POS_BROWNOUT] = src_bor;
      hw_set[rsc_pkg::POS_PIN]      = src_pin;
      hw_set[rsc_pkg::POS_SWRST]    = src_sw;
      hw_set[rsc_pkg::POS_WDT]      = src_wdt;
      hw_set[rsc_pkg::POS_CFGMIS]   = src_cm;
      hw_set[rsc_pkg::POS_TRAP]     = src_trap;
      hw_set[rsc_pkg::POS_ILLEGAL]  = src_illegal;

      next_st = st;
      // config word sampled every cycle so a reset takes its latest value
      next_st.cfg = initial_osc_select_bits_i;

      if (any_src) begin
         next_st.rst = 1'b1;
         next_st.cnt = CW'(STRETCH);
      end else if (st.cnt != '0) begin
         next_st.cnt = st.cnt - CW'(1);
      end else begin
         next_st.rst = 1'b0;
      end

      // software write first so hardware sets win in the same cycle;
      // a write only stores, it never feeds the reset path
      if (cause_wr_i) begin
         next_st.cause = cause_wdata_i & rsc_pkg::CAUSE_MASK;
      end
      if (src_por) begin
         next_st.cause = rsc_pkg::CAUSE_POR_VAL | hw_set;
      end else begin
         next_st.cause = next_st.cause | hw_set;
      end

      // oscillator selection reloaded while master reset is asserted
      if (st.rst) begin
         next_st.osc = rsc_pkg::OSC_RST_VAL;
         next_st.osc[rsc_pkg::OSC_NEW_POS +: rsc_pkg::OSC_SEL_W] = st.cfg;
         next_st.osc[rsc_pkg::OSC_CUR_POS +: rsc_pkg::OSC_SEL_W] =
            st.cfg;
      end
   end

   // ************************************************
   // state register
   // ************************************************
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         // block reset counts as power-on: flags take the power-on pattern
         st.rst   <= 1'b1;
         st.cnt   <= CW'(STRETCH);
         st.cause <= rsc_pkg::CAUSE_POR_VAL;
         st.osc   <= rsc_pkg::OSC_RST_VAL;
         st.cfg   <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign master_system_reset_o         = st.rst;
   assign reset_cause_register_o        = st.cause;
   assign oscillator_control_register_o = st.osc;
endmodule // rsc_top

// File: tb/rsc_monitor.sv
// checker: port properties of the reset source combiner
`timescale 1ns/100ps
module rsc_monitor #(parameter int unsigned STRETCH = 4) (
   input logic        mclk_i,
   input logic        rst_b_i,
   input logic        power_on_i,
   input logic        brownout_i,
   input logic        master_clear_pin_reset_b_i,
   input logic        reset_instr_i,
   input logic        watchdog_timeout_i,
   input logic        config_mismatch_i,
   input logic        trap_conflict_i,
   input logic [3:0]  illegal_cause_i,
   input logic [2:0]  initial_osc_select_bits_i,
   input logic        cause_wr_i,
   input logic [15:0] cause_wdata_i,
   input logic        master_system_reset_o,
   input logic [15:0] reset_cause_register_o,
   input logic [15:0] oscillator_control_register_o
);
   // histories let checks skip sources still in the synchronisers
   logic [3:0] sh, ph;
   logic [2:0] c1, c2;
   wire [15:0] c = reset_cause_register_o;
   wire r = master_system_reset_o;
   wire s = power_on_i | brownout_i | ~master_clear_pin_reset_b_i |
      reset_instr_i | watchdog_timeout_i | config_mismatch_i |
      trap_conflict_i | (|illegal_cause_i);
   wire q = !s && sh == 4'h0;
   always_ff @(posedge mclk_i) {sh, ph, c1, c2} <= {sh[2:0], s, ph[2:0],
      power_on_i, initial_osc_select_bits_i, c1};
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   property p_any; s |-> ##[1:4] r; endproperty
   a_any: assert property (p_any) else $error("no reset");
   property p_pin; !master_clear_pin_reset_b_i |-> ##[1:4] c[7]; endproperty
   a_pin: assert property (p_pin) else $error("no pin flag");
   property p_ill; |illegal_cause_i |-> ##[1:4] c[14]; endproperty
   a_ill: assert property (p_ill) else $error("no illegal flag");
   property p_por; power_on_i |-> ##[1:4] c[1:0] == 2'h3; endproperty
   a_por: assert property (p_por) else $error("no power flags");
   property p_keep; $fell(c[4]) |-> $past(cause_wr_i) || ph != 4'h0;
   endproperty
   a_keep: assert property (p_keep) else $error("flag lost");
   property p_nosw; q && !r |=> !r; endproperty
   a_nosw: assert property (p_nosw) else $error("stray reset");
   property p_wr; cause_wr_i && q |=>
      c == ($past(cause_wdata_i) & rsc_pkg::CAUSE_MASK); endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_osc; $fell(r) && c1 == c2 && c1 == initial_osc_select_bits_i
      |-> oscillator_control_register_o[10:8] == c1; endproperty
   a_osc: assert property (p_osc) else $error("osc not loaded");
   property p_blk;
      disable iff (1'b0) !rst_b_i |=> r && c == rsc_pkg::CAUSE_POR_VAL &&
         oscillator_control_register_o == rsc_pkg::OSC_RST_VAL;
   endproperty
   a_blk: assert property (p_blk) else $error("block reset wrong");
   property p_hold; $fell(r) |-> $past(r, STRETCH + 1); endproperty
   a_hold: assert property (p_hold) else $error("reset too short");
   c_por: cover property (power_on_i);
   c_src: cover property (s && !r);
   c_wr: cover property (cause_wr_i && q);
   c_fall: cover property ($fell(r));
endmodule // rsc_monitor
bind rsc_top rsc_monitor #(.STRETCH(STRETCH)) mon (
   .mclk_i                        (mclk_i),
   .rst_b_i                       (rst_b_i),
   .power_on_i                    (power_on_i),
   .brownout_i                    (brownout_i),
   .master_clear_pin_reset_b_i    (master_clear_pin_reset_b_i),
   .reset_instr_i                 (reset_instr_i),
   .watchdog_timeout_i            (watchdog_timeout_i),
   .config_mismatch_i             (config_mismatch_i),
   .trap_conflict_i               (trap_conflict_i),
   .illegal_cause_i               (illegal_cause_i),
   .initial_osc_select_bits_i     (initial_osc_select_bits_i),
   .cause_wr_i                    (cause_wr_i),
   .cause_wdata_i                 (cause_wdata_i),
   .master_system_reset_o         (master_system_reset_o),
   .reset_cause_register_o        (reset_cause_register_o),
   .oscillator_control_register_o (oscillator_control_register_o)
);

// File: tb/rsc_src_model.sv
// partner: reset sources as supplies, pin, watchdog and cpu drive them
`timescale 1ns/100ps
module rsc_src_model (
   input  logic        mclk_i,
   input  logic [10:0] req_i,
   output logic [10:0] src_o = 11'h004
);
   // bit 2 is the pin, active low, so an idle request holds it high
   always @(posedge mclk_i) src_o <= req_i ^ 11'h004;
endmodule // rsc_src_model

// File: tb/rsc_top_tb.sv
// testbench: reset source combiner fed by the source model
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
 $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module rsc_top_tb;
   logic        mclk_i = 0, rst_b_i = 0, cause_wr_i = 0, chk = 0;
   logic [2:0]  initial_osc_select_bits_i = 3'h5;
   logic [15:0] cause_wdata_i = 0, ex, reset_cause_register_o;
   logic [15:0] oscillator_control_register_o;
   logic        master_system_reset_o;
   logic [10:0] req = 0, src;
   logic [31:0] rs = 32'h00B13888;
   logic [32:0] q[$], e;
   int fail_count = 0, cmp_count = 0, pos[10] = '{1,7,6,4,9,15,14,14,14,14};
   wire [32:0] got = {master_system_reset_o,
      oscillator_control_register_o, reset_cause_register_o};
   always #2 mclk_i = ~mclk_i;
   rsc_src_model srcm (.mclk_i(mclk_i), .req_i(req), .src_o(src));
   rsc_top dut (
      .mclk_i                        (mclk_i),
      .rst_b_i                       (rst_b_i),
      .power_on_i                    (src[0]),
      .brownout_i                    (src[1]),
      .master_clear_pin_reset_b_i    (src[2]),
      .reset_instr_i                 (src[3]),
      .watchdog_timeout_i            (src[4]),
      .config_mismatch_i             (src[5]),
      .trap_conflict_i               (src[6]),
      .illegal_cause_i               (src[10:7]),
      .initial_osc_select_bits_i     (initial_osc_select_bits_i),
      .cause_wr_i                    (cause_wr_i),
      .cause_wdata_i                 (cause_wdata_i),
      .master_system_reset_o         (master_system_reset_o),
      .reset_cause_register_o        (reset_cause_register_o),
      .oscillator_control_register_o (oscillator_control_register_o)
   );
   // ***
   // drivers note each expectation; the watcher compares it later
   // ***
   function automatic logic [31:0] lf(logic [31:0] s);
      return {s[30:0], ^(s & 32'h80200003)};
   endfunction
   task automatic cyc(int n); repeat (n) @(posedge mclk_i); endtask
   task automatic note(logic [15:0] c);
      logic [15:0] o;
      o = rsc_pkg::OSC_RST_VAL;
      o[rsc_pkg::OSC_NEW_POS +: 3] = initial_osc_select_bits_i;
      o[rsc_pkg::OSC_CUR_POS +: 3] = initial_osc_select_bits_i;
      q.push_back({1'h0, o, c});
      chk <= 1; cyc(1); chk <= 0; cyc(1); $display("test done");
   endtask
   task automatic wrt(logic [15:0] d);
      cause_wr_i <= 1; cause_wdata_i <= d; cyc(1); cause_wr_i <= 0; cyc(1);
   endtask
   task automatic hit(logic [10:0] r, logic [15:0] f, bit w = 1'b0);
      rs = lf(rs); initial_osc_select_bits_i <= rs[2:0]; req <= r; cyc(2);
      req <= 0; cyc(2);
      // w writes zero while the synced sources still set their flags, so those flags stay set and only the others clear
      if (w) wrt(16'h0000);
      else cyc(2);
      cyc(2);
      for (int i = 0; i < 60 && master_system_reset_o !== 0; i++) cyc(1);
      note(f);
   endtask
   always @(posedge mclk_i) if (chk) begin
      e = q.pop_front(); `CHK(got, e)
   end
   initial begin
      cyc(4); rst_b_i <= 1; hit(0, 16'h0003);
      wrt(16'hFFFF); note(rsc_pkg::CAUSE_MASK);
      wrt(0); note(0); ex = 0;
      foreach (pos[k]) begin
         if (pos[k] == 14) begin wrt(0); ex = 0; end
         ex[pos[k]] = 1; hit(11'h1 << (k + 1), ex);
      end
      hit(11'h1, 16'h0003); wrt(0); hit(11'h50, 16'h8010);
      hit(11'h10, 16'h0010, 1'b1);
      rst_b_i <= 0; cyc(4); rst_b_i <= 1; hit(0, 16'h0003);
      rs = lf(rs); wrt(rs[31:16]);
      note(rs[31:16] & rsc_pkg::CAUSE_MASK);
      complete_run;
   end
   initial begin #40000; fail_count++; complete_run; end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
endmodule // rsc_top_tb
